// *** logic/lag_config.sv ***
// Link aggregation configuration registers and member-port selection.
//
// Operation
// - Control bit 3 turns address aggregation on.
// - Two groups, up to four members each.
// - Bits 1:0 pick the hash address source.
// - Membership bit 8 CPU, bits 5:0 ports.
// - Reset clears enable, selector and memberships.
// - Page 32h offsets; page register at FFh.
`timescale 1ns/1ps
module lag_config
    import lag_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic arst_n,
    // Paged byte register access.
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Frame lookup request.
    input wire logic frame_valid,
    input wire logic frame_group,
    input wire logic [47:0] frame_da,
    input wire logic [47:0] frame_sa,
    // Lookup answer.
    output logic sel_done,
    output logic sel_valid,
    output logic [3:0] sel_port,
    // Configuration view.
    output logic address_aggregation_on,
    output lag_pkg::lag_hash_t member_hash_source_select
);
    import lag_pkg::*;

    logic [7:0] page;
    logic [8:0] group_members [LAG_NUM_GROUPS];
    logic on_page;
    logic [7:0] next_rdata;

    // Folds a 48-bit address into one byte by exclusive or.
    function automatic logic [7:0] fold48(input logic [47:0] a);
        logic [7:0] f;
        f = 8'h00;
        for (int i = 0; i < 6; i++) begin
            f = f ^ a[i*8 +: 8];
        end
        return f;
    endfunction

    // Counts set bits of a membership field.
    function automatic logic [3:0] count_members(input logic [8:0] m);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 0; i < 9; i++) begin
            c = c + {3'h0, m[i]};
        end
        return c;
    endfunction

    // Returns the port number of the n-th set bit, counting from bit 0.
    function automatic logic [3:0] nth_member(input logic [8:0] m, input logic [3:0] n);
        logic [3:0] seen;
        logic [3:0] p;
        seen = 4'h0;
        p = 4'h0;
        for (int i = 0; i < 9; i++) begin
            if (m[i]) begin
                if (seen == n) begin
                    p = 4'(i);
                end
                seen = seen + 4'h1;
            end
        end
        return p;
    endfunction

    assign on_page = (page == LAG_PAGE_AGGREGATION);

    ////////////////////////////////////////////////////////////////////////////////
    // Page select, reachable from every page.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            page <= LAG_PAGE_RESET;
        end else if (reg_wr && reg_addr == LAG_OFS_PAGE) begin
            page <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control register. Reserved bits are not stored and read as zero.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            address_aggregation_on <= 1'b0;
            member_hash_source_select <= lag_hash_t'(LAG_HASH_RESET);
        end else if (reg_wr && on_page && reg_addr == LAG_OFS_CONTROL) begin
            address_aggregation_on <= reg_wdata[LAG_CTRL_ON_BIT];
            member_hash_source_select <=
                lag_hash_t'(reg_wdata[LAG_CTRL_HASH_MSB:LAG_CTRL_HASH_LSB]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Group membership registers, low byte holds ports 5..0, high byte bit 0 the CPU port.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int g = 0; g < LAG_NUM_GROUPS; g++) begin
                group_members[g] <= LAG_GROUP_RESET;
            end
        end else if (reg_wr && on_page) begin
            for (int g = 0; g < LAG_NUM_GROUPS; g++) begin
                if (reg_addr == LAG_OFS_GROUP0_LO + 8'(2 * g)) begin
                    group_members[g][7:0] <= reg_wdata & LAG_GROUP_VALID_MASK[7:0];
                end
                if (reg_addr == LAG_OFS_GROUP0_HI + 8'(2 * g)) begin
                    group_members[g][LAG_GROUP_CPU_BIT] <= reg_wdata[0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path; unmapped offsets and other pages read as zero, except the page register at FFh.
    always_comb begin
        next_rdata = 8'h00;
        if (reg_addr == LAG_OFS_PAGE) begin
            next_rdata = page;
        end else if (on_page) begin
            unique case (reg_addr)
                LAG_OFS_CONTROL: next_rdata = {4'h0, address_aggregation_on, 1'b0,
                                               member_hash_source_select};
                LAG_OFS_GROUP0_LO: next_rdata = group_members[0][7:0];
                LAG_OFS_GROUP0_HI: next_rdata = {7'h00, group_members[0][LAG_GROUP_CPU_BIT]};
                LAG_OFS_GROUP1_LO: next_rdata = group_members[1][7:0];
                LAG_OFS_GROUP1_HI: next_rdata = {7'h00, group_members[1][LAG_GROUP_CPU_BIT]};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            reg_rdata <= reg_rd ? next_rdata : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Member selection: the folded address byte modulo the member count picks a member,
    // so one address pair always lands on the same link.
    logic [7:0] hash_byte;
    logic [8:0] req_members;
    logic [3:0] req_count;
    logic [3:0] req_index;

    always_comb begin
        req_members = group_members[frame_group];
        req_count = count_members(req_members);
        unique case (member_hash_source_select)
            LAG_HASH_DA: hash_byte = fold48(frame_da);
            LAG_HASH_SA: hash_byte = fold48(frame_sa);
            default: hash_byte = fold48(frame_da) ^ fold48(frame_sa);
        endcase
        req_index = (req_count == 4'h0) ? 4'h0 : 4'(hash_byte % {4'h0, req_count});
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_done <= 1'b0;
            sel_valid <= 1'b0;
            sel_port <= 4'h0;
        end else begin
            sel_done <= frame_valid;
            sel_valid <= frame_valid && address_aggregation_on && req_count != 4'h0 &&
                         req_count <= 4'(LAG_MAX_MEMBERS);
            sel_port <= frame_valid ? nth_member(req_members, req_index) : 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    property p_enable_write;
        @(posedge core_clk) disable iff (!arst_n)
        reg_wr && on_page && reg_addr == LAG_OFS_CONTROL
            |=> address_aggregation_on == $past(reg_wdata[LAG_CTRL_ON_BIT]);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable not stored");

    property p_hash_write;
        @(posedge core_clk) disable iff (!arst_n)
        reg_wr && on_page && reg_addr == LAG_OFS_CONTROL
            |=> member_hash_source_select == $past(reg_wdata[1:0]);
    endproperty
    a_hash_write: assert property (p_hash_write) else $error("hash select not stored");

    property p_reserved_members;
        @(posedge core_clk) disable iff (!arst_n)
        group_members[0][7:6] == 2'h0 && group_members[1][7:6] == 2'h0;
    endproperty
    a_reserved_members: assert property (p_reserved_members) else $error("reserved set");

    property p_page_read;
        @(posedge core_clk) disable iff (!arst_n)
        reg_rd && reg_addr == LAG_OFS_PAGE |=> reg_rvalid && reg_rdata == $past(page);
    endproperty
    a_page_read: assert property (p_page_read) else $error("page read wrong");

    property p_other_page_zero;
        @(posedge core_clk) disable iff (!arst_n)
        reg_rd && !on_page && reg_addr != LAG_OFS_PAGE |=> reg_rdata == 8'h00;
    endproperty
    a_other_page_zero: assert property (p_other_page_zero) else $error("off-page data");

    property p_sel_needs_enable;
        @(posedge core_clk) disable iff (!arst_n)
        sel_valid |-> $past(address_aggregation_on) && sel_done;
    endproperty
    a_sel_needs_enable: assert property (p_sel_needs_enable) else $error("select while off");

    // Membership of the group requested in the previous cycle, sampled every cycle, so the chosen port can be checked against it.
    logic [8:0] past_members;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            past_members <= LAG_GROUP_RESET;
        end else begin
            past_members <= req_members;
        end
    end

    property p_sel_is_member;
        @(posedge core_clk) disable iff (!arst_n)
        frame_valid && address_aggregation_on && req_count != 4'h0 &&
            req_count <= 4'(LAG_MAX_MEMBERS)
            |=> sel_valid && past_members[sel_port];
    endproperty
    a_sel_is_member: assert property (p_sel_is_member) else $error("not a member");

    property p_sel_group_size;
        @(posedge core_clk) disable iff (!arst_n)
        frame_valid && req_count > 4'(LAG_MAX_MEMBERS) |=> !sel_valid;
    endproperty
    a_sel_group_size: assert property (p_sel_group_size) else $error("oversize group");

    property p_sel_stable;
        @(posedge core_clk) disable iff (!arst_n)
        frame_valid && !reg_wr ##1 frame_valid && $stable(frame_da) && $stable(frame_sa) &&
            $stable(frame_group) |=> $stable(sel_port);
    endproperty
    a_sel_stable: assert property (p_sel_stable) else $error("flow moved link");
endmodule // lag_config

// *** logic/lag_pkg.sv ***
// Constants for the link aggregation configuration block.
package lag_pkg;
    localparam logic [7:0] LAG_PAGE_AGGREGATION = 8'h32;
    localparam logic [7:0] LAG_OFS_CONTROL = 8'h00;
    localparam logic [7:0] LAG_OFS_GROUP0_LO = 8'h10;
    localparam logic [7:0] LAG_OFS_GROUP0_HI = 8'h11;
    localparam logic [7:0] LAG_OFS_GROUP1_LO = 8'h12;
    localparam logic [7:0] LAG_OFS_GROUP1_HI = 8'h13;
    localparam logic [7:0] LAG_OFS_PAGE = 8'hFF;
    localparam int LAG_CTRL_ON_BIT = 3;
    localparam int LAG_CTRL_HASH_MSB = 1;
    localparam int LAG_CTRL_HASH_LSB = 0;
    localparam int LAG_GROUP_CPU_BIT = 8;
    localparam int LAG_GROUP_PORT_MSB = 5;
    localparam int LAG_NUM_GROUPS = 2;
    localparam int LAG_MAX_MEMBERS = 4;
    localparam logic [8:0] LAG_GROUP_VALID_MASK = 9'h13F;
    localparam logic [7:0] LAG_PAGE_RESET = 8'h00;
    localparam logic [1:0] LAG_HASH_RESET = 2'h0;
    localparam logic [8:0] LAG_GROUP_RESET = 9'h000;
    localparam logic [3:0] LAG_CPU_PORT_NUM = 4'h8;
    typedef enum logic [1:0] {
        LAG_HASH_DA_SA = 2'h0,
        LAG_HASH_DA = 2'h1,
        LAG_HASH_SA = 2'h2,
        LAG_HASH_ILLEGAL = 2'h3
    } lag_hash_t;
endpackage

// *** verif/lag_host.sv ***
// Host processor model that reaches the paged byte registers.
`timescale 1ns/1ps
module lag_host (
    // Clock.
    input wire logic core_clk,
    // Register access.
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial begin
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // Reserved fields of the control and membership offsets go out as zero; other offsets pass unchanged.
    function automatic logic [7:0] legal(input logic [7:0] a, input logic [7:0] d);
        case (a)
            8'h00: legal = d & 8'h0B;
            8'h10, 8'h12: legal = d & 8'h3F;
            8'h11, 8'h13: legal = d & 8'h01;
            default: legal = d;
        endcase
    endfunction
    // Idle bus lines show the inverse of the last value so stale data is not mistaken.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_wr = 1'h1;
        reg_addr = a;
        reg_wdata = legal(a, d);
        @(negedge core_clk);
        reg_wr = 1'h0;
        reg_addr = ~a;
        reg_wdata = ~reg_wdata;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge core_clk);
        reg_rd = 1'h1;
        reg_addr = a;
        @(negedge core_clk);
        d = reg_rdata;
        v = reg_rvalid;
        reg_rd = 1'h0;
        reg_addr = ~a;
    endtask
endmodule // lag_host

// *** verif/tb.sv ***
// Self-checking testbench for the link aggregation configuration block.
`timescale 1ns/1ps
module tb;
    import lag_pkg::*;
    logic core_clk, arst_n, reg_wr, reg_rd, reg_rvalid, rd_ok, on;
    logic frame_valid, frame_group, sel_done, sel_valid, address_aggregation_on;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_data;
    logic [3:0] sel_port;
    logic [1:0] hsel;
    logic [47:0] frame_da, frame_sa;
    logic [8:0] grp [2];
    logic [7:0] offs [5] = '{8'h00, 8'h10, 8'h11, 8'h12, 8'h13};
    lag_hash_t member_hash_source_select;
    int bad_count, num_checks, cycles;
    lag_config i_lag_config (.core_clk(core_clk), .arst_n(arst_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .frame_valid(frame_valid), .frame_group(frame_group),
        .frame_da(frame_da), .frame_sa(frame_sa), .sel_done(sel_done), .sel_valid(sel_valid),
        .sel_port(sel_port), .address_aggregation_on(address_aggregation_on),
        .member_hash_source_select(member_hash_source_select));
    lag_host i_lag_host (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'h0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            end_sim();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t ns: got 0x%h expected 0x%h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        i_lag_host.rd(a, rd_data, rd_ok);
        chk({7'h00, rd_ok, rd_data}, {8'h01, exp});
    endtask
    // Expected lane: XOR of the six bytes, modulo member count, n-th set bit.
    task automatic look(input logic g, input logic [47:0] da, input logic [47:0] sa);
        logic [47:0] src;
        logic [7:0] h;
        logic [3:0] port;
        int cnt, idx, k;
        src = (hsel == 2'h1) ? da : (hsel == 2'h2) ? sa : da ^ sa;
        h = src[7:0] ^ src[15:8] ^ src[23:16] ^ src[31:24] ^ src[39:32] ^ src[47:40];
        cnt = $countones(grp[g]);
        idx = (cnt == 0) ? 0 : h % cnt;
        port = 4'h0;
        k = 0;
        for (int b = 0; b < 9; b++) begin
            if (grp[g][b]) begin
                if (k == idx) port = b[3:0];
                k++;
            end
        end
        @(negedge core_clk);
        frame_valid = 1'h1;
        frame_group = g;
        frame_da = da;
        frame_sa = sa;
        @(negedge core_clk);
        frame_valid = 1'h0;
        frame_da = ~da;
        frame_sa = ~sa;
        chk({15'h0000, sel_done}, 16'h0001);
        chk({15'h0000, sel_valid}, {15'h0000, on && cnt > 0 && cnt <= 4});
        if (on && cnt > 0 && cnt <= 4) chk({12'h000, sel_port}, {12'h000, port});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        arst_n = 1'h0;
        frame_valid = 1'h0;
        frame_group = 1'h0;
        frame_da = 48'h0;
        frame_sa = 48'h0;
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        arst_n = 1'h1;
        chk({15'h0000, address_aggregation_on}, 16'h0000);
        chk({14'h0000, member_hash_source_select}, 16'h0000);
        i_lag_host.wr(8'h00, 8'h08);
        rchk(8'h00, 8'h00);
        i_lag_host.wr(8'hFF, 8'h32);
        rchk(8'hFF, 8'h32);
        foreach (offs[i]) rchk(offs[i], 8'h00);
        i_lag_host.wr(8'h00, 8'h0B);
        rchk(8'h00, 8'h0B);
        chk({15'h0000, address_aggregation_on}, 16'h0001);
        chk({14'h0000, member_hash_source_select}, 16'h0003);
        i_lag_host.wr(8'h05, 8'h5A);
        rchk(8'h05, 8'h00);
        i_lag_host.wr(8'h10, 8'h0F);
        i_lag_host.wr(8'h12, 8'h21);
        i_lag_host.wr(8'h13, 8'h01);
        rchk(8'h10, 8'h0F);
        rchk(8'h12, 8'h21);
        rchk(8'h13, 8'h01);
        grp[0] = 9'h00F;
        grp[1] = 9'h121;
        on = 1'h1;
        for (int s = 0; s < 4; s++) begin
            i_lag_host.wr(8'h00, 8'h08 | 8'(s));
            hsel = 2'(s);
            for (int n = 0; n < 8; n++) begin
                look(n[0], 48'h0123_4567_89AB * (n + 1), 48'hA5C3_1E77_0F42 + 48'(n * 29));
            end
        end
        // Same flow held for two cycles must stay on port 5 of group 1 (fold 04h mod 3).
        @(negedge core_clk);
        frame_valid = 1'h1;
        frame_group = 1'h1;
        frame_da = 48'h4;
        frame_sa = 48'h0;
        repeat (2) begin
            @(negedge core_clk);
            chk({11'h000, sel_valid, sel_port}, 16'h0015);
        end
        frame_valid = 1'h0;
        i_lag_host.wr(8'h10, 8'h1F);
        grp[0] = 9'h01F;
        look(1'h0, 48'h1, 48'h2);
        i_lag_host.wr(8'h12, 8'h00);
        i_lag_host.wr(8'h13, 8'h00);
        grp[1] = 9'h000;
        look(1'h1, 48'h3, 48'h4);
        i_lag_host.wr(8'h00, 8'h00);
        on = 1'h0;
        look(1'h0, 48'h5, 48'h6);
        @(negedge core_clk);
        arst_n = 1'h0;
        @(negedge core_clk);
        arst_n = 1'h1;
        rchk(8'hFF, 8'h00);
        i_lag_host.wr(8'hFF, 8'h32);
        rchk(8'h10, 8'h00);
        end_sim();
    end
endmodule // tb
